// >>> rtl/fsbau_consts.svh
// Purpose: Shared offsets, field positions and timing counts of the unit
// Assumes: 25 MHz system clock
// Notes:   Definitions only
`ifndef FSBAU_CONSTS_SVH
`define FSBAU_CONSTS_SVH

// Timing
`define FSBAU_CLK_NS       40
`define FSBAU_DELAY_NS     400
`define FSBAU_DELAY_CYC    ((`FSBAU_DELAY_NS + `FSBAU_CLK_NS - 1) / `FSBAU_CLK_NS)

// Word layout
`define FSBAU_SIGN_BIT     63
`define FSBAU_EXP_HI       62
`define FSBAU_EXP_LO       54
`define FSBAU_HALF_SHIFT   6'h20
`define FSBAU_GUARD_BITS   9'h000

// Exponent constants: bias 400 octal plus 55 shifts = 100 110 111
`define FSBAU_NORM_EXP     9'h137
`define FSBAU_FIX_MAX_EXP  9'h120
`define FSBAU_INT_MAX      32'h7FFF_FFFF

// Instruction field positions inside the upper field (bit 23 at index 0)
`define FSBAU_KIND_ARITH   2'h2
`define FSBAU_IR_RIGHT     2
`define FSBAU_IR_LEFT      3
`define FSBAU_IR_DOUBLE    4

`endif

// >>> rtl/fsbau_pkg.sv
// Purpose: Types shared by the shift, bit and float arithmetic unit
// Assumes: Constants live in fsbau_consts.svh
// Notes:   Operation codes come from the CPU decoder
package fsbau_pkg;

  typedef enum logic [3:0] {
    OP_SHIFT = 4'h0, OP_BSET = 4'h1, OP_BCLR = 4'h2, OP_BCOM = 4'h3,
    OP_BSKZ  = 4'h4, OP_BSKO = 4'h5, OP_ITOS = 4'h6, OP_ITOD = 4'h7,
    OP_FIX   = 4'h8, OP_DTOI = 4'h9, OP_RTOI = 4'hA, OP_RDTOI = 4'hB,
    OP_FADD  = 4'hC, OP_FSUB = 4'hD
  } fsbau_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } fsbau_state_t;

  typedef struct packed {
    logic       right;
    logic       rotate;
    logic       fill;
    logic       off;
    logic [5:0] count;
  } fsbau_shctl_t;

  typedef struct packed {
    fsbau_op_t   op;
    logic        dbl;
    logic [7:0]  ir_hi;
    logic [5:0]  ir_lo;
    logic [63:0] a;
    logic [63:0] b;
  } fsbau_req_t;

  typedef struct packed {
    logic [63:0] result;
    logic        ovf;
    logic        unf;
    logic        selbit;
  } fsbau_res_t;

endpackage : fsbau_pkg

// >>> rtl/fsbau_prienc.sv
// Purpose: Leading one finder over a 55-bit mantissa field
// Assumes: Bit 54 is the normalized mantissa position
// Notes:   Count is the left shift that brings the top one to bit 54
`timescale 1ns/1ns
module fsbau_prienc (
  // Input field
  input  wire logic [54:0] vec_i,
  // Shift count and all-zero flag
  output logic [5:0]       lz_o,
  output logic             zero_o
);

  always_comb begin
    lz_o   = 6'h00;
    zero_o = 1'b1;
    // Highest set bit wins as the loop runs upward
    for (int i = 0; i < 55; i++) begin
      if (vec_i[i]) begin
        lz_o   = 6'(54 - i);
        zero_o = 1'b0;
      end
    end
  end

endmodule : fsbau_prienc

// >>> rtl/fsbau_shifter.sv
// Purpose: Two stage 64-bit shifter, coarse by eights then fine by ones
// Assumes: Count bits 5:3 drive the coarse stage, 2:0 the fine stage
// Notes:   Delay does not depend on the count
`timescale 1ns/1ns
module fsbau_shifter (
  // Control and data
  input  wire fsbau_pkg::fsbau_shctl_t ctl_i,
  input  wire logic [63:0]             data_i,
  // Result
  output logic [63:0]                  data_o
);

  logic [63:0] stg [0:2];

  function automatic logic [63:0] shift_one(input logic [63:0] d,
                                            input logic [5:0]  n,
                                            input logic        right,
                                            input logic        rot,
                                            input logic        fill);
    logic [127:0] w;
    logic [127:0] s;
    if (right) begin
      w = rot ? {d, d} : {{64{fill}}, d};
      s = w >> n;
      return s[63:0];
    end else begin
      w = rot ? {d, d} : {d, 64'h0000_0000_0000_0000};
      s = w << n;
      return s[127:64];
    end
  endfunction : shift_one

  assign stg[0] = data_i;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_stage
      localparam logic [5:0] MASK = (g == 0) ? 6'h38 : 6'h07;
      assign stg[g+1] = shift_one(stg[g], ctl_i.count & MASK, ctl_i.right,
                                  ctl_i.rotate, ctl_i.fill & stg[g][63]);
    end
  endgenerate

  assign data_o = ctl_i.off ? 64'h0000_0000_0000_0000 : stg[2];

endmodule : fsbau_shifter

// >>> rtl/fsbau_top.sv
// Purpose: Shift, bit, convert and float add/sub unit beside a slave CPU
// Assumes: CPU strobes, operands and op code are on the MCLK_I domain
// Notes:   Operands latched at start, answer after a fixed delay
//
// Overview of operation
// - Coarse eights stage feeds fine ones stage
// - Coarse count bits 3-5, fine 0-2
// - 32-bit shift uses upper half, low zero
// - Arithmetic right shift copies bit 63
// - Left and logical shifts fill zeros
// - Bit ops rotate selected bit to 0
// - Left stage rotates altered word back
// - Selected bit returned for skip decision
// - Integer to float: arithmetic shift right 32
// - Negate negative integer, find leading one
// - Exponent is 100110111 minus shift count
// - Drop bit 54, merge exponent, keep sign
// - Float to int shift; overflow above 32
// - Rounding overflow at largest integer plus one
// - Overflow disables right stage, gives maximum
// - Negate for negative float, pass unshifted
// - Exponent subtract picks larger, shift smaller
// - Far exponents: larger operand is answer
// - Signs and opcode choose add or subtract
// - Hidden one inserted at bit 54
// - Underflow on zero result, ready strobe
// - Fixed 400 ns delay after any start
// - Mantissa overflow: shift right, exponent up
// - Normalize left, exponent down per place
// - Equal exponent borrow: complement adder output
`timescale 1ns/1ns
`include "fsbau_consts.svh"
module fsbau_top (
  // Clock and reset
  input  wire logic        MCLK_I,
  input  wire logic        RSTN_I,
  // Start strobes
  input  wire logic        START_FLOAT_ADD_I,
  input  wire logic        START_FLOAT_SUB_I,
  input  wire logic        START_OPERATION_I,
  // Instruction and operands
  input  wire logic [3:0]  OP_CODE_I,
  input  wire logic        DOUBLE_PREC_I,
  input  wire logic [7:0]  INSTR_HI_I,
  input  wire logic [5:0]  INSTR_LO_I,
  input  wire logic [63:0] OPERAND_A_I,
  input  wire logic [63:0] OPERAND_B_I,
  // Results
  output logic [63:0]      RESULT_O,
  output logic             RESULT_READY_STROBE_O,
  output logic             OVERFLOW_FLAG_O,
  output logic             FLOAT_UNDERFLOW_FLAG_O,
  output logic             SELECTED_BIT_O
);

  fsbau_pkg::fsbau_state_t state_ff, nxt_state;
  fsbau_pkg::fsbau_req_t   req_ff,   nxt_req;
  fsbau_pkg::fsbau_res_t   res_ff,   nxt_res, calc;
  fsbau_pkg::fsbau_shctl_t shr_ctl,  shl_ctl;
  logic [3:0]              cnt_ff,   nxt_cnt;
  logic                    rdy_ff,   nxt_rdy;
  logic [63:0]             shr_in,   shr_out, shl_in, shl_out;
  logic [54:0]             enc_in;
  logic [5:0]              enc_lz;
  logic                    enc_zero;
  logic [1:0]              kind;
  logic                    go_right, go_left, dbl_shift, fsub;
  logic [8:0]              ea, eb, align;
  logic [9:0]              ediff, fix_sh;
  logic                    b_big, far, main_sign, op_add, exp_rng_ovf;
  logic [63:0]             main_w, minor_w;
  logic                    sel, rnd, rnd_ovf, carry_up, neg;
  logic [63:0]             bit_mod, mag, mant;
  logic [31:0]             int_raw, int_rnd, int_val;
  logic [64:0]             sum;
  logic [8:0]              exp_flo;
  logic [10:0]             exp_f;

  function automatic logic op_is_bit(input fsbau_pkg::fsbau_op_t op);
    return op inside {fsbau_pkg::OP_BSET, fsbau_pkg::OP_BCLR,
                      fsbau_pkg::OP_BCOM, fsbau_pkg::OP_BSKZ,
                      fsbau_pkg::OP_BSKO};
  endfunction : op_is_bit

  function automatic logic op_is_fix(input fsbau_pkg::fsbau_op_t op);
    return op inside {fsbau_pkg::OP_FIX, fsbau_pkg::OP_DTOI,
                      fsbau_pkg::OP_RTOI, fsbau_pkg::OP_RDTOI};
  endfunction : op_is_fix

  function automatic logic op_is_float(input fsbau_pkg::fsbau_op_t op);
    return op inside {fsbau_pkg::OP_FADD, fsbau_pkg::OP_FSUB};
  endfunction : op_is_float

  //////////////////////////////////////////////////////////////////////////
  // Field decode

  assign kind      = req_ff.ir_hi[1:0];
  assign go_right  = req_ff.ir_hi[`FSBAU_IR_RIGHT];
  assign go_left   = req_ff.ir_hi[`FSBAU_IR_LEFT];
  assign dbl_shift = req_ff.ir_hi[`FSBAU_IR_DOUBLE];
  assign fsub      = (req_ff.op == fsbau_pkg::OP_FSUB);
  assign ea        = req_ff.a[`FSBAU_EXP_HI:`FSBAU_EXP_LO];
  assign eb        = req_ff.b[`FSBAU_EXP_HI:`FSBAU_EXP_LO];

  assign ediff   = {1'b0, eb} - {1'b0, ea};
  assign b_big   = ~ediff[9];
  assign align   = b_big ? ediff[8:0] : 9'(~ediff[8:0] + 9'h001);
  assign main_w  = b_big ? req_ff.b : req_ff.a;
  assign minor_w = b_big ? req_ff.a : req_ff.b;
  assign far     = |align[8:6];
  // Subtrahend sign flips for subtract when it is the main operand
  assign main_sign = b_big ? (req_ff.b[63] ^ fsub) : req_ff.a[63];
  assign op_add  = (req_ff.a[63] == req_ff.b[63]) ^ fsub;

  assign fix_sh  = {1'b0, `FSBAU_NORM_EXP} - {1'b0, ea};
  assign exp_rng_ovf = (ea > `FSBAU_FIX_MAX_EXP);

  //////////////////////////////////////////////////////////////////////////
  // Right stage input

  always_comb begin
    shr_ctl = '0;
    shr_in  = req_ff.a;
    case (req_ff.op)
      fsbau_pkg::OP_SHIFT: begin
        shr_in        = dbl_shift ? req_ff.a
                                  : {req_ff.a[63:32], 32'h0000_0000};
        shr_ctl.right  = 1'b1;
        shr_ctl.rotate = ~kind[1];
        shr_ctl.fill   = (kind == `FSBAU_KIND_ARITH);
        shr_ctl.count  = go_right ? req_ff.ir_lo : 6'h00;
      end
      fsbau_pkg::OP_BSET, fsbau_pkg::OP_BCLR, fsbau_pkg::OP_BCOM,
      fsbau_pkg::OP_BSKZ, fsbau_pkg::OP_BSKO: begin
        shr_ctl.right  = 1'b1;
        shr_ctl.rotate = 1'b1;
        shr_ctl.count  = req_ff.ir_lo;
      end
      fsbau_pkg::OP_ITOS, fsbau_pkg::OP_ITOD: begin
        shr_in        = {req_ff.a[63:32], 32'h0000_0000};
        shr_ctl.right = 1'b1;
        shr_ctl.fill  = 1'b1;
        shr_ctl.count = `FSBAU_HALF_SHIFT;
      end
      fsbau_pkg::OP_FIX, fsbau_pkg::OP_DTOI,
      fsbau_pkg::OP_RTOI, fsbau_pkg::OP_RDTOI: begin
        // One guard bit below the integer feeds the rounding
        shr_in        = {8'h00, 1'b1, req_ff.a[53:0], 1'b0};
        shr_ctl.right = 1'b1;
        shr_ctl.count = fix_sh[5:0];
        shr_ctl.off   = exp_rng_ovf | (fix_sh > 10'h03F);
      end
      fsbau_pkg::OP_FADD, fsbau_pkg::OP_FSUB: begin
        shr_in        = {1'b1, minor_w[53:0], `FSBAU_GUARD_BITS};
        shr_ctl.right = 1'b1;
        shr_ctl.count = align[5:0];
        shr_ctl.off   = far;
      end
      default: ;
    endcase
  end

  fsbau_shifter u_shr (
    .ctl_i  (shr_ctl),
    .data_i (shr_in),
    .data_o (shr_out)
  );

  //////////////////////////////////////////////////////////////////////////
  // Between the stages

  always_comb begin
    sel     = shr_out[0];
    bit_mod = shr_out;
    case (req_ff.op)
      fsbau_pkg::OP_BSET: bit_mod[0] = 1'b1;
      fsbau_pkg::OP_BCLR: bit_mod[0] = 1'b0;
      fsbau_pkg::OP_BCOM: bit_mod[0] = ~shr_out[0];
      default: ;
    endcase
    mag = shr_out[63] ? (~shr_out + 64'h0000_0000_0000_0001) : shr_out;
    int_raw = exp_rng_ovf ? `FSBAU_INT_MAX : shr_out[32:1];
    rnd     = shr_out[0] & (req_ff.op inside {fsbau_pkg::OP_RTOI,
                                              fsbau_pkg::OP_RDTOI});
    rnd_ovf = rnd & (int_raw == `FSBAU_INT_MAX);
    int_rnd = int_raw + {31'h0000_0000, rnd};
    int_val = req_ff.a[63] ? (~int_rnd + 32'h0000_0001) : int_rnd;
    sum = op_add ? {1'b0, 1'b1, main_w[53:0], `FSBAU_GUARD_BITS}
                   + {1'b0, shr_out}
                 : {1'b0, 1'b1, main_w[53:0], `FSBAU_GUARD_BITS}
                   - {1'b0, shr_out};
    carry_up = op_add & sum[64];
    neg      = ~op_add & sum[64];
    if (carry_up) begin
      mant = sum[64:1];
    end else if (neg) begin
      mant = ~sum[63:0] + 64'h0000_0000_0000_0001;
    end else begin
      mant = sum[63:0];
    end
    enc_in = op_is_float(req_ff.op) ? mant[63:9] : mag[54:0];
  end

  fsbau_prienc u_enc (
    .vec_i  (enc_in),
    .lz_o   (enc_lz),
    .zero_o (enc_zero)
  );

  //////////////////////////////////////////////////////////////////////////
  // Left stage input

  always_comb begin
    shl_ctl = '0;
    shl_in  = shr_out;
    case (req_ff.op)
      fsbau_pkg::OP_SHIFT: begin
        shl_ctl.rotate = ~kind[1];
        shl_ctl.count  = go_left ? req_ff.ir_lo : 6'h00;
      end
      fsbau_pkg::OP_BSET, fsbau_pkg::OP_BCLR, fsbau_pkg::OP_BCOM,
      fsbau_pkg::OP_BSKZ, fsbau_pkg::OP_BSKO: begin
        shl_in         = bit_mod;
        shl_ctl.rotate = 1'b1;
        shl_ctl.count  = req_ff.ir_lo;
      end
      fsbau_pkg::OP_ITOS, fsbau_pkg::OP_ITOD: begin
        shl_in        = mag;
        shl_ctl.count = enc_lz;
      end
      fsbau_pkg::OP_FIX, fsbau_pkg::OP_DTOI,
      fsbau_pkg::OP_RTOI, fsbau_pkg::OP_RDTOI: begin
        shl_in = {int_val, 32'h0000_0000};
      end
      fsbau_pkg::OP_FADD, fsbau_pkg::OP_FSUB: begin
        shl_in        = mant;
        shl_ctl.count = enc_lz;
      end
      default: ;
    endcase
  end

  fsbau_shifter u_shl (
    .ctl_i  (shl_ctl),
    .data_i (shl_in),
    .data_o (shl_out)
  );

  //////////////////////////////////////////////////////////////////////////
  // Result assembly

  assign exp_flo = `FSBAU_NORM_EXP - {3'h0, enc_lz};
  assign exp_f   = {2'b00, main_w[`FSBAU_EXP_HI:`FSBAU_EXP_LO]}
                   + {10'h000, carry_up} - {5'h00, enc_lz};

  always_comb begin
    calc        = '0;
    calc.result = shl_out;
    calc.selbit = op_is_bit(req_ff.op) & sel;
    case (req_ff.op)
      fsbau_pkg::OP_ITOS, fsbau_pkg::OP_ITOD: begin
        if (enc_zero) begin
          calc.result = 64'h0000_0000_0000_0000;
          calc.unf    = 1'b1;
        end else begin
          calc.result = {req_ff.a[63], exp_flo, shl_out[53:0]};
          if (req_ff.op == fsbau_pkg::OP_ITOS) begin
            calc.result[31:0] = 32'h0000_0000;
          end
        end
      end
      fsbau_pkg::OP_FIX, fsbau_pkg::OP_DTOI,
      fsbau_pkg::OP_RTOI, fsbau_pkg::OP_RDTOI: begin
        calc.ovf = exp_rng_ovf | rnd_ovf;
      end
      fsbau_pkg::OP_FADD, fsbau_pkg::OP_FSUB: begin
        if (enc_zero || exp_f[10]) begin
          calc.result = 64'h0000_0000_0000_0000;
          calc.unf    = 1'b1;
        end else begin
          calc.result = {main_sign ^ neg, exp_f[8:0], shl_out[62:9]};
          calc.ovf    = exp_f[9];
          if (!req_ff.dbl) begin
            calc.result[31:0] = 32'h0000_0000;
          end
        end
      end
      default: ;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    nxt_state = state_ff;
    nxt_req   = req_ff;
    nxt_cnt   = cnt_ff;
    nxt_res   = res_ff;
    nxt_rdy   = 1'b0;
    case (state_ff)
      fsbau_pkg::ST_IDLE: begin
        if (START_FLOAT_ADD_I || START_FLOAT_SUB_I || START_OPERATION_I) begin
          nxt_state     = fsbau_pkg::ST_BUSY;
          nxt_cnt       = 4'(`FSBAU_DELAY_CYC - 1);
          nxt_req.op    = START_FLOAT_ADD_I ? fsbau_pkg::OP_FADD :
                          START_FLOAT_SUB_I ? fsbau_pkg::OP_FSUB :
                          fsbau_pkg::fsbau_op_t'(OP_CODE_I);
          nxt_req.dbl   = DOUBLE_PREC_I;
          nxt_req.ir_hi = INSTR_HI_I;
          nxt_req.ir_lo = INSTR_LO_I;
          nxt_req.a     = OPERAND_A_I;
          nxt_req.b     = OPERAND_B_I;
        end
      end
      fsbau_pkg::ST_BUSY: begin
        if (cnt_ff == 4'h0) begin
          nxt_state = fsbau_pkg::ST_IDLE;
          nxt_res   = calc;
          nxt_rdy   = 1'b1;
        end else begin
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
      default: nxt_state = fsbau_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_ff <= fsbau_pkg::ST_IDLE;
      req_ff   <= '0;
      cnt_ff   <= 4'h0;
      res_ff   <= '0;
      rdy_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      req_ff   <= nxt_req;
      cnt_ff   <= nxt_cnt;
      res_ff   <= nxt_res;
      rdy_ff   <= nxt_rdy;
    end
  end

  assign RESULT_O               = res_ff.result;
  assign RESULT_READY_STROBE_O  = rdy_ff;
  assign OVERFLOW_FLAG_O        = res_ff.ovf;
  assign FLOAT_UNDERFLOW_FLAG_O = res_ff.unf;
  assign SELECTED_BIT_O         = res_ff.selbit;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  chk_ready_delay: assert property (
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (state_ff == fsbau_pkg::ST_IDLE
     && (START_FLOAT_ADD_I || START_FLOAT_SUB_I || START_OPERATION_I))
      |-> ##1 !RESULT_READY_STROBE_O [*5] ##1 !RESULT_READY_STROBE_O [*5]
          ##1 RESULT_READY_STROBE_O)
    else $error("ready not at fixed delay");

  chk_ready_pulse: assert property (
    @(posedge MCLK_I) disable iff (!RSTN_I)
    $rose(RESULT_READY_STROBE_O) |=> !RESULT_READY_STROBE_O)
    else $error("ready wider than one cycle");

  chk_bit_set: assert property (
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (RESULT_READY_STROBE_O && req_ff.op == fsbau_pkg::OP_BSET)
      |-> RESULT_O == (req_ff.a | (64'h0000_0000_0000_0001 << req_ff.ir_lo)))
    else $error("bit set result wrong");

  chk_bit_skip: assert property (
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (RESULT_READY_STROBE_O
     && req_ff.op inside {fsbau_pkg::OP_BSKZ, fsbau_pkg::OP_BSKO})
      |-> SELECTED_BIT_O == req_ff.a[req_ff.ir_lo])
    else $error("selected bit wrong");

  chk_logic_single: assert property (
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (RESULT_READY_STROBE_O && req_ff.op == fsbau_pkg::OP_SHIFT
     && req_ff.ir_hi[4:0] == 5'h07)
      |-> RESULT_O == ({req_ff.a[63:32], 32'h0000_0000} >> req_ff.ir_lo))
    else $error("single logical right shift wrong");

  chk_arith_fill: assert property (
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (RESULT_READY_STROBE_O && req_ff.op == fsbau_pkg::OP_SHIFT
     && req_ff.ir_hi[4:0] == 5'h16)
      |-> RESULT_O == 64'($signed(req_ff.a) >>> req_ff.ir_lo))
    else $error("arithmetic right shift wrong");

  chk_flo_sign: assert property (
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (RESULT_READY_STROBE_O && req_ff.op == fsbau_pkg::OP_ITOD
     && req_ff.a[63:32] != 32'h0000_0000)
      |-> RESULT_O[63] == req_ff.a[63] && !FLOAT_UNDERFLOW_FLAG_O)
    else $error("converted sign wrong");

  chk_fix_range: assert property (
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (RESULT_READY_STROBE_O && op_is_fix(req_ff.op)
     && req_ff.a[62:54] > `FSBAU_FIX_MAX_EXP)
      |-> OVERFLOW_FLAG_O)
    else $error("integer overflow missed");

  chk_float_zero: assert property (
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (RESULT_READY_STROBE_O && op_is_float(req_ff.op))
      |-> FLOAT_UNDERFLOW_FLAG_O == (RESULT_O == 64'h0000_0000_0000_0000))
    else $error("underflow flag disagrees with result");

endmodule : fsbau_top

// >>> verification/float_shift_bit_arith_unit_tb.sv
// Purpose: Self-checking bench for the shift, bit and float unit
// Assumes: Double precision add and subtract, except the last add, which runs single precision
// Notes:   Shift, convert and fix expected values come from the bench functions below
`timescale 1ns/1ns
module float_shift_bit_arith_unit_tb;
  logic        clk, rstn, add, sub, opr, dbl, rdy, ovf, unf, sel, skip;
  logic [3:0]  op, o;
  logic [7:0]  hi, h;
  logic [5:0]  lo, l;
  logic [31:0] r, v;
  logic [63:0] a, b, res, x;
  int          num_errors, comparisons, seed, cyc, i;
  localparam logic [63:0] F_ONE = {1'b0, 9'h101, 54'h0};
  localparam logic [63:0] F_TWO = {1'b0, 9'h102, 54'h0};

  fsbau_top uut (
    .MCLK_I(clk), .RSTN_I(rstn), .START_FLOAT_ADD_I(add),
    .START_FLOAT_SUB_I(sub), .START_OPERATION_I(opr), .OP_CODE_I(op),
    .DOUBLE_PREC_I(dbl), .INSTR_HI_I(hi), .INSTR_LO_I(lo),
    .OPERAND_A_I(a), .OPERAND_B_I(b), .RESULT_O(res),
    .RESULT_READY_STROBE_O(rdy), .OVERFLOW_FLAG_O(ovf),
    .FLOAT_UNDERFLOW_FLAG_O(unf), .SELECTED_BIT_O(sel));
  fsbau_host host (.clk_i(clk), .ready_i(rdy), .selbit_i(sel),
    .add_o(add), .sub_o(sub), .opr_o(opr));

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [63:0] e, g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic results;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic go(input logic [1:0] k, input logic [3:0] c,
                    input logic [7:0] ih, input logic [5:0] il,
                    input logic [63:0] p, q);
    {op, hi, lo, a, b} = {c, ih, il, p, q};
    host.run(k, c[0], cyc, skip);
    chk("latency", 10, cyc);
    if (cyc >= 40) begin
      num_errors++;
      results();
    end
  endtask : go

  task automatic fa(input logic [1:0] k, input logic [63:0] p, q, e);
    go(k, 4'h0, 8'h00, 6'h00, p, q);
    chk("float", e, res);
    chk("unf", e == 0, unf);
  endtask : fa

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [63:0] shf(logic [7:0] ih, logic [5:0] c,
                                      logic [63:0] p);
    logic [63:0] w;
    w = ih[4] ? p : {p[63:32], 32'h0000_0000};
    if (ih[2])
      case (ih[1:0])
        2'h2:    w = $signed(w) >>> c;
        2'h3:    w = w >> c;
        default: w = 64'({w, w} >> c);
      endcase
    if (ih[3])
      w = ih[1] ? w << c : 64'(({w, w} << c) >> 64);
    return w;
  endfunction : shf

  function automatic logic [63:0] itof(logic [31:0] iv);
    logic [31:0] m;
    int          p;
    m = iv[31] ? -iv : iv;
    p = 31;
    while (p > 0 && !m[p])
      p--;
    if (m == 0)
      return 64'h0;
    return {iv[31], 9'h101 + 9'(p), 54'(64'(m) << (54 - p))};
  endfunction : itof

  function automatic logic [63:0] fix(logic [63:0] p, logic rnd);
    logic [54:0] m;
    logic [31:0] q;
    int          s;
    m = {1'b1, p[53:0]};
    s = 311 - int'(p[62:54]);
    q = 32'(m >> s) + 32'(rnd & m[s-1]);
    if (p[62:54] > 9'h120)
      q = 32'h7FFF_FFFF;
    return {p[63] ? -q : q, 32'h0000_0000};
  endfunction : fix

  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    {rstn, op, hi, lo, a, b, dbl} = '0;
    seed = 32'h0000_32E9;
    repeat (12) @(posedge clk);
    #1;
    chk("reset", 0, res);
    chk("reset flags", 0, {60'h0, rdy, ovf, unf, sel});
    rstn = 1'b1;
    dbl = 1'b1;
    // Counts 0 and 63 first, then random kinds and widths
    for (i = 0; i < 60; i++) begin
      r = $random(seed);
      h = {3'h0, r[4], r[3] ? 2'b10 : 2'b01, r[1:0]};
      l = (i < 2) ? {6{i[0]}} : r[10:5];
      x = {$random(seed), $random(seed)};
      go(2'h0, 4'h0, h, l, x, 64'h0);
      chk("shift", shf(h, l, x), res);
    end
    for (i = 0; i < 40; i++) begin
      o = 4'h1 + 4'(i % 5);
      l = 6'($random(seed));
      x = {$random(seed), $random(seed)};
      go(2'h0, o, 8'h00, l, x, 64'h0);
      chk("selbit", x[l], sel);
      if (o > 4'h3)
        chk("skip", x[l] == o[0], skip);
      else
        chk("bitop", o == 4'h1 ? x | (64'h1 << l) : o == 4'h2 ?
            x & ~(64'h1 << l) : x ^ (64'h1 << l), res);
    end
    for (i = 0; i < 20; i++) begin
      v = i == 0 ? 32'h0 : i == 1 ? 32'hFFFF_FFFF : i == 2 ?
          32'h8000_0000 : $random(seed);
      o = 4'h6 + 4'(i % 2);
      go(2'h0, o, 8'h00, 6'h00, {v, 32'h0000_0000}, 64'h0);
      x = itof(v) & {32'hFFFF_FFFF, {32{o[0]}}};
      chk("itof", x, res);
      chk("unf", v == 0, unf);
    end
    // Exponents kept below 288 so values fit; the last one overflows
    for (i = 0; i < 30; i++) begin
      o = 4'h8 + 4'(i % 4);
      x = {$random(seed), $random(seed)};
      x[62:54] = 9'h101 + 9'($unsigned($random(seed)) % 30);
      if (i == 29)
        x[62:54] = 9'h12C;
      go(2'h0, o, 8'h00, 6'h00, x, 64'h0);
      chk("fix", fix(x, o[1]), res);
      chk("ovf", x[62:54] > 9'h120, ovf);
    end
    go(2'h0, 4'hB, 8'h00, 6'h00, {1'b0, 9'h11F, {54{1'b1}}}, 64'h0);
    chk("rndovf", 1, ovf);
    fa(2'h1, F_ONE, F_ONE, F_TWO);
    fa(2'h1, F_TWO, F_ONE, {1'b0, 9'h102, 54'h20_0000_0000_0000});
    fa(2'h2, F_TWO, F_ONE, F_ONE);
    fa(2'h2, F_ONE, F_ONE, 64'h0);
    fa(2'h1, F_ONE, F_ONE | 64'h8000_0000_0000_0000, 64'h0);
    fa(2'h2, F_ONE, F_TWO, F_ONE | 64'h8000_0000_0000_0000);
    fa(2'h1, {1'b0, 9'h190, 54'h0}, F_ONE, {1'b0, 9'h190, 54'h0});
    fa(2'h2, F_ONE, {1'b0, 9'h101, 54'h20_0000_0000_0000},
       {1'b1, 9'h100, 54'h0});
    fa(2'h2, {1'b0, 9'h101, 54'h20_0000_0000_0000}, F_ONE,
       {1'b0, 9'h100, 54'h0});
    fa(2'h1, F_ONE | 64'h1, F_ONE | 64'h1, F_TWO | 64'h1);
    dbl = 1'b0;
    fa(2'h1, F_ONE | 64'h1, F_ONE | 64'h1, F_TWO);
    results();
  end
endmodule : float_shift_bit_arith_unit_tb

// >>> verification/fsbau_host.sv
// Purpose: Host CPU side: start pulses, ready wait, skip decision
// Assumes: Operands are driven by the bench before run is called
// Notes:   The ready wait is bounded, and the bench counts a timeout
`timescale 1ns/1ns
module fsbau_host (
  // Clock and answers
  input  wire logic clk_i,
  input  wire logic ready_i,
  input  wire logic selbit_i,
  // Start strobes
  output logic      add_o,
  output logic      sub_o,
  output logic      opr_o
);
  initial {add_o, sub_o, opr_o} = 3'h0;

  // One cycle start, so a second request is never seen while busy
  task automatic run(input logic [1:0] k, input logic one,
                     output int cyc, output logic skip);
    @(posedge clk_i);
    #1;
    {add_o, sub_o, opr_o} = {k == 2'h1, k == 2'h2, k == 2'h0};
    @(posedge clk_i);
    #1;
    {add_o, sub_o, opr_o} = 3'h0;
    cyc = 0;
    while (ready_i !== 1'b1 && cyc < 40) begin
      @(posedge clk_i);
      #1;
      cyc++;
    end
    skip = (selbit_i === one);
  endtask : run
endmodule : fsbau_host
